// >>> rtl/led_ctrl_top.sv
// two-wire target interface, register map and sink control of the led driver
//
// Overview of operation
// - start is sda falling while scl high
// - stop is sda rising while scl high
// - bus busy from start until stop
// - repeated start restarts address reception
// - sda changes only while scl low
// - answer only target address 0110110
// - direction bit zero writes, one reads
// - second byte addresses, third byte is data
// - eight bits msb first, then ack slot
// - device pulls sda low on ninth pulse
// - bit 0 enables primary sink
// - bit 1 enables secondary sink
// - shared mode applies primary level to both
// - bits 3 and 4 are ramp rate
// - bit 5 makes secondary a feedback input
// - bits 6 and 7 read one, read-only
// - shared mode: primary enable drives both sinks
// - otherwise each sink own enable and level
// - analog powered when any enable bit set
// - only seven low level bits set current
module led_ctrl_top
   import led_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic bus_busy,
   output sink_ctl_type sink_ctl
);
   // link side: shift logic runs on scl edges; sda is sampled on scl rise
   typedef enum logic [2:0] {
      st_idle, st_addr, st_reg, st_data, st_read, st_ignore
   } link_state_type;

   link_state_type state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] reg_ptr_reg;
   logic rd_dir_reg;
   logic ack_reg;
   logic drive_low_reg;
   logic start_tog_reg;
   logic stop_tog_reg;
   logic start_seen_reg;
   logic wr_tog_reg;
   wr_req_type wr_req_reg;
   logic rstn_link_a_reg;
   logic rstn_link_reg;
   logic [7:0] rd_byte_link;

   // start/stop detection: sda edges while scl high are clocked by sda itself
   // sda has no edges during reset, so these toggles need an asynchronous clear
   always_ff @(negedge sda_in or negedge rstn) begin
      if (!rstn) begin
         start_tog_reg <= 1'b0;
      end else if (scl) begin
         start_tog_reg <= ~start_tog_reg;
      end
   end

   always_ff @(posedge sda_in or negedge rstn) begin
      if (!rstn) begin
         stop_tog_reg <= 1'b0;
      end else if (scl) begin
         stop_tog_reg <= ~stop_tog_reg;
      end
   end

   // scl domain reset from the system reset, released via two stages
   always_ff @(negedge scl) begin
      rstn_link_a_reg <= rstn;
      rstn_link_reg <= rstn_link_a_reg;
   end

   // a start is recognised by the scl domain at the next scl fall
   logic start_ack_reg;
   wire start_pend = start_tog_reg ^ start_ack_reg;

   // sample sda on scl rise, msb first
   always_ff @(posedge scl) begin
      if (bit_cnt_reg < 4'd8) begin
         shift_reg <= {shift_reg[6:0], sda_in};
      end
   end

   // byte framing and acknowledge on scl falling edges
   always_ff @(negedge scl) begin
      if (!rstn_link_reg) begin
         state_reg <= st_idle;
         bit_cnt_reg <= 4'd0;
         reg_ptr_reg <= 8'h00;
         rd_dir_reg <= 1'b0;
         ack_reg <= 1'b0;
         drive_low_reg <= 1'b0;
         start_ack_reg <= start_tog_reg;
         wr_tog_reg <= 1'b0;
         wr_req_reg <= '0;
      end else if (start_pend) begin
         // first fall after a start: begin address reception
         start_ack_reg <= start_tog_reg;
         state_reg <= st_addr;
         bit_cnt_reg <= 4'd0;
         ack_reg <= 1'b0;
         drive_low_reg <= 1'b0;
      end else if (state_reg != st_idle && state_reg != st_ignore) begin
         if (bit_cnt_reg == 4'd7) begin
            // eighth bit just sampled: decide on ack
            bit_cnt_reg <= 4'd8;
            drive_low_reg <= 1'b0;
            unique case (state_reg)
               st_addr: begin
                  ack_reg <= (shift_reg[7:1] == dev_addr);
                  rd_dir_reg <= shift_reg[0];
               end
               st_read: ack_reg <= 1'b0;
               default: ack_reg <= 1'b1;
            endcase
         end else if (bit_cnt_reg == 4'd8) begin
            // ninth pulse over: move on
            bit_cnt_reg <= 4'd0;
            ack_reg <= 1'b0;
            unique case (state_reg)
               st_addr: begin
                  if (!ack_reg) begin
                     state_reg <= st_ignore;
                  end else if (rd_dir_reg) begin
                     state_reg <= st_read;
                     drive_low_reg <= ~rd_byte_link[7];
                  end else begin
                     state_reg <= st_reg;
                  end
               end
               st_reg: begin
                  reg_ptr_reg <= shift_reg;
                  state_reg <= st_data;
               end
               st_data: begin
                  wr_req_reg <= '{addr: reg_ptr_reg, data: shift_reg};
                  wr_tog_reg <= ~wr_tog_reg;
                  state_reg <= st_ignore;
               end
               default: begin
                  state_reg <= st_ignore;
                  drive_low_reg <= 1'b0;
               end
            endcase
         end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            if (state_reg == st_read) begin
               drive_low_reg <= ~rd_byte_link[3'd6 - bit_cnt_reg[2:0]];
            end
         end
      end
   end

   // sda is pulled low for ack or for a read zero; never released high actively
   wire link_pull = rstn_link_reg & (ack_reg | drive_low_reg);

   // bring link events into clk domain
   logic [3:0] tog_sync;
   logic scl_s;
   level_sync #(.width(4), .init(4'h0)) u_tog_sync (
      .clk(clk),
      .rstn(rstn),
      .d({start_tog_reg, stop_tog_reg, wr_tog_reg, link_pull}),
      .q(tog_sync)
   );
   level_sync #(.width(1), .init(1'b1)) u_scl_sync (
      .clk(clk),
      .rstn(rstn),
      .d(scl),
      .q(scl_s)
   );

   // system side state
   logic [7:0] general_reg;
   logic [7:0] pin_func_reg;
   logic [7:0] io_pin_reg;
   logic [7:0] pat_reg [4];
   logic [7:0] primary_reg;
   logic [7:0] secondary_reg;
   logic start_q_reg;
   logic stop_q_reg;
   logic wr_q_reg;
   logic busy_reg;
   logic [7:0] rd_byte_reg;
   sink_ctl_type ctl_next;

   wire start_ev = tog_sync[3] ^ start_q_reg;
   wire stop_ev = tog_sync[2] ^ stop_q_reg;
   wire wr_ev = tog_sync[1] ^ wr_q_reg;
   wire [7:0] wr_addr = wr_req_reg.addr;
   wire [7:0] wr_data = wr_req_reg.data;

   // write data is stable: request register and toggle move on one scl fall, and the toggle reaches clk two stages later
   always_ff @(posedge clk) begin
      if (!rstn) begin
         start_q_reg <= 1'b0;
         stop_q_reg <= 1'b0;
         wr_q_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (ce) begin
         start_q_reg <= tog_sync[3];
         stop_q_reg <= tog_sync[2];
         wr_q_reg <= tog_sync[1];
         // start wins over a stop seen in the same cycle
         if (start_ev) begin
            busy_reg <= 1'b1;
         end else if (stop_ev) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // register writes
   always_ff @(posedge clk) begin
      if (!rstn) begin
         general_reg <= rst_general;
         pin_func_reg <= rst_pin_func;
         io_pin_reg <= rst_io_pin;
         pat_reg <= '{default: rst_pat};
         primary_reg <= rst_level;
         secondary_reg <= rst_level;
      end else if (ce && wr_ev) begin
         unique case (wr_addr)
            off_general: general_reg <= wr_data | general_ro_mask;
            off_pin_func: pin_func_reg <= wr_data;
            off_io_pin: io_pin_reg <= wr_data | io_pin_ro_mask;
            off_pat0, off_pat1, off_pat2, off_pat3: pat_reg[wr_addr[1:0]] <= wr_data;
            off_primary: primary_reg <= wr_data;
            off_secondary: secondary_reg <= wr_data;
            default: ;
         endcase
      end
   end

   // read mux; unmapped addresses read zero
   wire [7:0] ptr_s = reg_ptr_reg;
   wire [7:0] rd_mux =
      (ptr_s == off_general) ? general_reg :
      (ptr_s == off_pin_func) ? pin_func_reg :
      (ptr_s == off_io_pin) ? io_pin_reg :
      (ptr_s[7:2] == off_pat0[7:2]) ? pat_reg[ptr_s[1:0]] :
      (ptr_s == off_primary) ? primary_reg :
      (ptr_s == off_secondary) ? secondary_reg : 8'h00;

   // read byte loaded while scl is high and held while scl is low so the link sees it settled
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_byte_reg <= 8'h00;
      end else if (ce && scl_s) begin
         rd_byte_reg <= rd_mux;
      end
   end
   assign rd_byte_link = rd_byte_reg;

   sink_decode u_decode (
      .general(general_reg),
      .primary_level(primary_reg),
      .secondary_level(secondary_reg),
      .ctl(ctl_next)
   );

   // registered outputs
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sink_ctl <= '0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         bus_busy <= 1'b0;
      end else if (ce) begin
         sink_ctl <= ctl_next;
         sda_out <= 1'b0;
         sda_oe <= tog_sync[0];
         bus_busy <= busy_reg;
      end
   end
endmodule : led_ctrl_top

// >>> rtl/led_ctrl_pkg.sv
// shared constants and carrier types for the two-wire led control block
package led_ctrl_pkg;
   localparam logic [6:0] dev_addr = 7'h36;
   localparam logic [7:0] off_general = 8'h10;
   localparam logic [7:0] off_pin_func = 8'h80;
   localparam logic [7:0] off_io_pin = 8'h81;
   localparam logic [7:0] off_pat0 = 8'h90;
   localparam logic [7:0] off_pat1 = 8'h91;
   localparam logic [7:0] off_pat2 = 8'h92;
   localparam logic [7:0] off_pat3 = 8'h93;
   localparam logic [7:0] off_primary = 8'ha0;
   localparam logic [7:0] off_secondary = 8'hb0;
   localparam logic [7:0] rst_general = 8'hc0;
   localparam logic [7:0] rst_pin_func = 8'hf8;
   localparam logic [7:0] rst_io_pin = 8'hfc;
   localparam logic [7:0] rst_pat = 8'h00;
   localparam logic [7:0] rst_level = 8'h80;
   localparam logic [7:0] general_ro_mask = 8'hc0;
   localparam logic [7:0] io_pin_ro_mask = 8'hfc;
   localparam int bit_primary_en = 0;
   localparam int bit_secondary_en = 1;
   localparam int bit_shared = 2;
   localparam int bit_ramp_lo = 3;
   localparam int bit_ramp_hi = 4;
   localparam int bit_feedback = 5;
   localparam int level_bits = 7;

   // one received register write, carried from the link domain
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } wr_req_type;

   // decoded sink controls
   typedef struct packed {
      logic primary_sink_enable;
      logic secondary_sink_enable;
      logic feedback_supply_mode;
      logic analog_enable;
      logic [1:0] ramp_rate;
      logic [6:0] primary_current;
      logic [6:0] secondary_current;
   } sink_ctl_type;
endpackage : led_ctrl_pkg

// >>> rtl/level_sync.sv
// two flip-flop synchroniser for a level
module level_sync
   import led_ctrl_pkg::*;
#(
   parameter int width = 1,
   parameter logic [width-1:0] init = '0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [width-1:0] d,
   output logic [width-1:0] q
);
   logic [width-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_reg <= init;
         q <= init;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : level_sync

// >>> rtl/sink_decode.sv
// decode of the general control and level registers into sink controls
module sink_decode
   import led_ctrl_pkg::*;
(
   input wire logic [7:0] general,
   input wire logic [7:0] primary_level,
   input wire logic [7:0] secondary_level,
   output sink_ctl_type ctl
);
   wire en_p = general[bit_primary_en];
   wire en_s = general[bit_secondary_en];
   wire shared = general[bit_shared];
   wire fb = general[bit_feedback];

   // sink enables by mode
   assign ctl.primary_sink_enable = en_p;
   assign ctl.secondary_sink_enable = fb ? 1'b0 : (shared ? en_p : en_s);
   assign ctl.feedback_supply_mode = fb;
   assign ctl.analog_enable = en_p | en_s | fb;
   assign ctl.ramp_rate = {general[bit_ramp_hi], general[bit_ramp_lo]};
   // top level bit is a don't care
   assign ctl.primary_current = primary_level[level_bits-1:0];
   assign ctl.secondary_current = shared ? primary_level[level_bits-1:0]
                                         : secondary_level[level_bits-1:0];
endmodule : sink_decode

// >>> test/led_ctrl_monitor.sv
// port checker for the two-wire led control block
module led_ctrl_monitor
   import led_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic bus_busy,
   input wire sink_ctl_type sink_ctl
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // raw wire edges; the design adds a few cycles of sync delay
   property p_start; $fell(sda_in) && scl && $past(scl) |-> ##[1:6] bus_busy; endproperty
   property p_stop; $rose(sda_in) && scl && $past(scl) |-> ##[1:6] !bus_busy; endproperty
   property p_busy_up; $rose(bus_busy) |-> scl && !sda_in; endproperty
   property p_busy_dn; $fell(bus_busy) |-> scl && sda_in; endproperty
   property p_oe_low; $changed(sda_oe) |-> !scl; endproperty
   property p_oe_busy; sda_oe |-> bus_busy; endproperty
   property p_drain; sda_out == 1'b0; endproperty
   property p_fb; sink_ctl.feedback_supply_mode |-> !sink_ctl.secondary_sink_enable; endproperty
   property p_analog; sink_ctl.primary_sink_enable || sink_ctl.secondary_sink_enable
      || sink_ctl.feedback_supply_mode |-> sink_ctl.analog_enable; endproperty
   // controls move only as a result of a write frame
   property p_quiet; $changed(sink_ctl) && $past(rstn, 4) |-> bus_busy; endproperty
   a_start: assert property (p_start) else $error("no busy after start");
   a_stop: assert property (p_stop) else $error("busy after stop");
   a_busy_up: assert property (p_busy_up) else $error("busy rose without start");
   a_busy_dn: assert property (p_busy_dn) else $error("busy fell without stop");
   a_oe_low: assert property (p_oe_low) else $error("sda moved with scl high");
   a_oe_busy: assert property (p_oe_busy) else $error("sda pulled while idle");
   a_drain: assert property (p_drain) else $error("sda driven high");
   a_fb: assert property (p_fb) else $error("secondary on in feedback mode");
   a_analog: assert property (p_analog) else $error("analog off while enabled");
   a_quiet: assert property (p_quiet) else $error("controls changed while idle");
   c_busy: cover property ($rose(bus_busy));
   c_ack: cover property ($rose(sda_oe));
   c_analog: cover property ($rose(sink_ctl.analog_enable));
endmodule : led_ctrl_monitor

bind led_ctrl_top led_ctrl_monitor u_mon (.clk(clk), .rstn(rstn), .ce(ce), .scl(scl),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy),
   .sink_ctl(sink_ctl));

// >>> test/twi_master_model.sv
// two-wire bus master model: drives scl, pulls sda low
module twi_master_model (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   // slow enough for the target sync; odd step keeps phase off clk
   localparam real tq = 16.1;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // data moves only while scl low, sampled late in high
   task automatic bit_io(input logic b, output logic r);
      #tq sda_pull = !b;
      #tq scl = 1'b1;
      #tq r = sda;
      scl = 1'b0;
   endtask : bit_io
   // free pulses with sda released, to step the link reset
   task automatic idle(input int n);
      repeat (n) begin
         #tq scl = 1'b0;
         #tq scl = 1'b1;
      end
   endtask : idle
   task automatic start;
      if (!scl) begin
         #tq sda_pull = 1'b0;
         #tq scl = 1'b1;
      end
      #tq sda_pull = 1'b1;
      #(2 * tq) scl = 1'b0;
   endtask : start
   task automatic stop;
      #tq sda_pull = 1'b1;
      #tq scl = 1'b1;
      #tq sda_pull = 1'b0;
      #(2 * tq);
   endtask : stop
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r,
      output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(!mack, a);
      ack = !a;
   endtask : xfer
endmodule : twi_master_model

// >>> test/tb_led_driver_i2c_register_control.sv
// self-checking bench for the two-wire led control block
module tb_led_driver_i2c_register_control
   import led_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic scl;
   logic m_pull;
   logic sda_out;
   logic sda_oe;
   logic bus_busy;
   sink_ctl_type sink_ctl;
   wire sda;
   int miscompares = 0;
   int checks = 0;
   int seed = 32'hba78;
   logic [7:0] mem [logic [7:0]];
   always #2.5 clk = ~clk;
   // one frozen cycle in sixteen; the ack path has slack for it
   logic [3:0] ce_cnt = 4'h0;
   always @(posedge clk) begin
      ce_cnt <= ce_cnt + 4'h1;
      ce <= ce_cnt != 4'hf;
   end
   // wired-and bus with pull-up
   assign sda = (sda_oe ? sda_out : 1'b1) & !m_pull;
   twi_master_model u_m (.scl(scl), .sda_pull(m_pull), .sda(sda));
   led_ctrl_top u_dut (.clk(clk), .rstn(rstn), .ce(ce), .scl(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy), .sink_ctl(sink_ctl));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude;
      if (miscompares == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // expected sink controls from register contents
   function automatic sink_ctl_type ectl(input logic [7:0] g, p, s);
      sink_ctl_type c;
      c.primary_sink_enable = g[0];
      c.feedback_supply_mode = g[5];
      c.secondary_sink_enable = !g[5] && (g[2] ? g[0] : g[1]);
      c.analog_enable = g[0] | g[1] | g[5];
      c.ramp_rate = g[4:3];
      c.primary_current = p[6:0];
      c.secondary_current = g[2] ? p[6:0] : s[6:0];
      return c;
   endfunction : ectl
   task automatic wr(input logic [6:0] da, input logic [7:0] ra, input logic [7:0] d);
      logic [7:0] r;
      logic a;
      u_m.start();
      u_m.xfer({da, 1'b0}, 1'b0, r, a);
      chk(a, da == dev_addr);
      u_m.xfer(ra, 1'b0, r, a);
      chk(a, da == dev_addr);
      u_m.xfer(d, 1'b0, r, a);
      chk(a, da == dev_addr);
      u_m.stop();
   endtask : wr
   task automatic rd(input logic [7:0] ra, output logic [7:0] v);
      logic [7:0] r;
      logic a;
      u_m.start();
      u_m.xfer({dev_addr, 1'b0}, 1'b0, r, a);
      u_m.xfer(ra, 1'b0, r, a);
      u_m.start();
      u_m.xfer({dev_addr, 1'b1}, 1'b0, r, a);
      chk(a, 1'b1);
      u_m.xfer(8'hff, 1'b0, v, a);
      u_m.stop();
   endtask : rd
   // every mapped register plus one unmapped place
   task automatic check_all;
      logic [7:0] v;
      foreach (mem[a]) begin
         rd(a, v);
         chk(v, mem[a]);
      end
      rd(8'h55, v);
      chk(v, 8'h00);
   endtask : check_all
   initial begin
      logic [7:0] v;
      logic [7:0] ra;
      logic [7:0] d;
      logic [7:0] tgt [5];
      logic [7:0] corner [4];
      sink_ctl_type s;
      sink_ctl_type e;
      tgt = '{off_general, off_primary, off_secondary, off_pat0, off_pat3};
      corner = '{8'h3f, 8'h05, 8'h22, 8'h1a};
      mem[8'h10] = 8'hc0;
      mem[8'h80] = 8'hf8;
      mem[8'h81] = 8'hfc;
      mem[8'h90] = 8'h00;
      mem[8'h91] = 8'h00;
      mem[8'h92] = 8'h00;
      mem[8'h93] = 8'h00;
      mem[8'ha0] = 8'h80;
      mem[8'hb0] = 8'h80;
      // link reset needs scl falls while rstn is low
      fork
         u_m.idle(3);
         repeat (20) @(posedge clk);
      join
      @(posedge clk);
      rstn <= 1'b1;
      u_m.idle(3);
      check_all();
      wr(dev_addr ^ 7'h01, off_general, 8'h3f);
      check_all();
      for (int i = 0; i < 16; i++) begin
         ra = i < 4 ? off_general : tgt[$unsigned($random(seed)) % 5];
         d = i < 4 ? corner[i] : 8'($random(seed));
         wr(dev_addr, ra, d);
         mem[ra] = ra == off_general ? d | 8'hc0 : d;
         repeat (4) @(posedge clk);
         s = sink_ctl;
         e = ectl(mem[off_general], mem[off_primary], mem[off_secondary]);
         chk(s, e);
         chk(bus_busy, 1'b0);
         rd(ra, v);
         chk(v, mem[ra]);
      end
      check_all();
      conclude();
   end
   // cut a hang well past the expected run length
   initial begin
      #400us;
      miscompares++;
      conclude();
   end
endmodule : tb_led_driver_i2c_register_control
